// ---- bpc_pkg.sv ----
// shared constants and types for the bidirectional port with change interrupt
package bpc_pkg;
    localparam int unsigned ADDR_W   = 9;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned PINS     = 8;
    localparam int unsigned WATCH_LO = 4;   // lowest watched pin of the upper nibble
    localparam int unsigned WATCH_N  = 4;

    // register map
    localparam logic [8:0] ADDR_PORT        = 9'h106;
    localparam logic [8:0] ADDR_IRQ_CTRL    = 9'h10b;
    localparam logic [8:0] ADDR_OPTIONS     = 9'h181;
    localparam logic [8:0] ADDR_DIRECTION   = 9'h186;
    localparam logic [8:0] ADDR_IRQ_CTRL_M  = 9'h18b;
    localparam logic [8:0] ADDR_EVT_STATUS  = 9'h1c0;
    localparam logic [8:0] ADDR_EVT_MASK    = 9'h1c1;

    // reset values
    localparam logic [7:0] RST_OPTIONS      = 8'hff;
    localparam logic [7:0] RST_DIRECTION    = 8'hff;
    localparam logic [7:0] RST_LATCH        = 8'h00;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [3:0] RST_WATCH        = 4'h0;

    // field positions
    localparam int unsigned PULLUP_DIS_BIT  = 7;
    localparam int unsigned EVT_CHANGE_BIT  = 0;
    localparam int unsigned EVT_WAKE_BIT    = 1;
    localparam int unsigned EVT_N           = 2;

    // interrupt control register layout
    typedef struct packed {
        logic       global_irq_enable;
        logic [2:0] other_bits;
        logic       change_irq_enable;
        logic [1:0] other_flags;
        logic       change_irq_flag;
    } bpc_irq_ctrl_s;

    // register access request from software
    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [8:0]       addr;
        logic [7:0]       wdata;
    } bpc_req_s;
endpackage

// ---- bpc_sync3.sv ----
// three-stage pin synchroniser, output moves once stages two and three agree
module bpc_sync3 (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic pin_raw,
    output logic      pin_stable
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // s1 feeds only s2, never any logic
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a level only when two late stages agree
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_stable <= 1'b0;
        end else if (s2_q == s3_q) begin
            pin_stable <= s3_q;
        end
    end
endmodule

// ---- bpc_port.sv ----
// eight-pin bidirectional port with pull-ups and upper-nibble change interrupt
// Summary of operation
// RULE1: eight pins, each made input or output by its own direction bit.
// RULE2: direction 1 floats the driver, direction 0 drives the output latch on the pin.
// RULE3: clearing option bit 7 turns on the weak pull-ups of all input pins together.
// RULE4: a pin set as output never has its pull-up on.
// RULE5: after reset pull-ups are off and option and direction read all ones.
// RULE6: only the upper four pins are watched and output pins among them are ignored.
// RULE7: watched inputs are compared with the value caught at the last port access and any mismatch sets flag bit 0.
// RULE8: any port read or write recaptures the comparison value and ends the mismatch.
// RULE9: a lasting mismatch keeps setting the flag, so software accesses the port then clears the flag.
// RULE10: a change interrupt can wake the core from its halt state.
// RULE11: optionally a change coinciding with a port read is lost, as on some variants.
// RULE12: the flag sets whatever the enable bits hold.
// RULE13: software should clear a flag before enabling its interrupt.
// RULE14: software should not poll the port while using change detection.
// RULE15: pins are synchronised on the core clock before comparison.
// RULE16: the change request is raised only when flag, change enable and global enable are all set.
// RULE17: a clearing write in the same cycle as a new mismatch leaves the flag set.
module bpc_port #(
    parameter bit LOSE_ON_READ = 1'b0
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [8:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe_n,
    output logic      [7:0] pullup_en,
    input  wire logic       halt,
    output logic            wake,
    output logic            change_irq_req,
    output logic            irq
);
    bpc_pkg::bpc_req_s      req;
    bpc_pkg::bpc_irq_ctrl_s irq_ctrl_q;
    bpc_pkg::bpc_irq_ctrl_s irq_ctrl_d;
    logic [7:0]             latch_q;
    logic [7:0]             dir_q;
    logic [7:0]             option_q;
    logic [7:0]             pins_stable;
    logic [3:0]             watch_q;
    logic [3:0]             watch_pins;
    logic [3:0]             watch_inputs;
    logic                   mismatch;
    logic                   port_access;
    logic                   lost_hit;
    logic                   change_set;
    logic                   ctrl_wr;
    logic [1:0]             evt_status_q;
    logic [1:0]             evt_mask_q;
    logic [1:0]             evt_set;
    logic [7:0]             rd_value;

    assign req = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wdata};

    // per-pin synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < bpc_pkg::PINS; gi++) begin : g_sync
            bpc_sync3 u_sync (
                .core_clk   (core_clk),
                .reset      (reset),
                .pin_raw    (pin_in[gi]),
                .pin_stable (pins_stable[gi])   // RULE15
            );
        end
    endgenerate

    // decode helpers
    assign port_access = (req.wr | req.rd) && (req.addr == bpc_pkg::ADDR_PORT);
    assign ctrl_wr     = req.wr && ((req.addr == bpc_pkg::ADDR_IRQ_CTRL) ||
                                    (req.addr == bpc_pkg::ADDR_IRQ_CTRL_M));

    // output latch, software write only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            latch_q <= bpc_pkg::RST_LATCH;
        end else if (req.wr && req.addr == bpc_pkg::ADDR_PORT) begin
            latch_q <= req.wdata;
        end
    end

    // direction register, all inputs after reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dir_q <= bpc_pkg::RST_DIRECTION;   // RULE5
        end else if (req.wr && req.addr == bpc_pkg::ADDR_DIRECTION) begin
            dir_q <= req.wdata;                // RULE1
        end
    end

    // option register; only bit 7 steers this block, rest is storage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            option_q <= bpc_pkg::RST_OPTIONS;  // RULE5
        end else if (req.wr && req.addr == bpc_pkg::ADDR_OPTIONS) begin
            option_q <= req.wdata;
        end
    end

    // pin drivers and pull-ups straight from flops
    assign pin_out   = latch_q;
    assign pin_oe_n  = dir_q;                                     // RULE2
    assign pullup_en = {bpc_pkg::PINS{~option_q[bpc_pkg::PULLUP_DIS_BIT]}} // RULE3
                       & dir_q;                                   // RULE4

    // change comparison on the watched nibble
    assign watch_pins   = pins_stable[bpc_pkg::WATCH_LO +: bpc_pkg::WATCH_N];
    assign watch_inputs = dir_q[bpc_pkg::WATCH_LO +: bpc_pkg::WATCH_N];  // RULE6
    assign mismatch     = |((watch_pins ^ watch_q) & watch_inputs);      // RULE7
    // variant loss: a change landing on a port read is dropped
    assign lost_hit     = LOSE_ON_READ && req.rd && port_access;         // RULE11
    assign change_set   = mismatch && !lost_hit;                         // RULE9

    // comparison value recaptured on every port access
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            watch_q <= bpc_pkg::RST_WATCH;
        end else if (port_access) begin
            watch_q <= watch_pins;             // RULE8
        end
    end

    // interrupt control next value; hardware set beats software clear
    always_comb begin
        irq_ctrl_d = irq_ctrl_q;
        if (ctrl_wr) begin
            irq_ctrl_d = bpc_pkg::bpc_irq_ctrl_s'(req.wdata);
        end
        if (change_set) begin
            irq_ctrl_d.change_irq_flag = 1'b1; // RULE12 RULE17
        end
    end

    // both map addresses reach one register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_ctrl_q <= bpc_pkg::bpc_irq_ctrl_s'(bpc_pkg::RST_ZERO);
        end else begin
            irq_ctrl_q <= irq_ctrl_d;
        end
    end

    // request and wake are plain gating of register bits
    assign change_irq_req = irq_ctrl_q.change_irq_flag && irq_ctrl_q.change_irq_enable
                            && irq_ctrl_q.global_irq_enable;          // RULE16
    // wake needs only the change enable, as the core is halted anyway
    assign wake = halt && irq_ctrl_q.change_irq_flag
                  && irq_ctrl_q.change_irq_enable;                    // RULE10

    // sticky event status, write one to clear, set wins
    assign evt_set[bpc_pkg::EVT_CHANGE_BIT] = change_set;
    assign evt_set[bpc_pkg::EVT_WAKE_BIT]   = wake;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            evt_status_q <= 2'h0;
        end else if (req.wr && req.addr == bpc_pkg::ADDR_EVT_STATUS) begin
            evt_status_q <= (evt_status_q & ~req.wdata[1:0]) | evt_set;
        end else begin
            evt_status_q <= evt_status_q | evt_set;
        end
    end

    // event mask, a one lets the event through
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            evt_mask_q <= 2'h0;
        end else if (req.wr && req.addr == bpc_pkg::ADDR_EVT_MASK) begin
            evt_mask_q <= req.wdata[1:0];
        end
    end

    assign irq = |(evt_status_q & evt_mask_q);

    // read mux; port reads give the synchronised pins, unmapped read zero
    always_comb begin
        unique case (req.addr)
            bpc_pkg::ADDR_PORT:       rd_value = pins_stable;
            bpc_pkg::ADDR_IRQ_CTRL,
            bpc_pkg::ADDR_IRQ_CTRL_M: rd_value = irq_ctrl_q;
            bpc_pkg::ADDR_OPTIONS:    rd_value = option_q;
            bpc_pkg::ADDR_DIRECTION:  rd_value = dir_q;
            bpc_pkg::ADDR_EVT_STATUS: rd_value = {6'h00, evt_status_q};
            bpc_pkg::ADDR_EVT_MASK:   rd_value = {6'h00, evt_mask_q};
            default:                  rd_value = bpc_pkg::RST_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata <= bpc_pkg::RST_ZERO;
        end else if (req.rd) begin
            rdata <= rd_value;
        end else begin
            rdata <= bpc_pkg::RST_ZERO;
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_watched_change;
        (watch_pins[0] != watch_q[0]) && watch_inputs[0] && !lost_hit;
    endsequence

    sequence s_pin_settle;
        $changed(pin_in[bpc_pkg::WATCH_LO]) ##1 $stable(pin_in[bpc_pkg::WATCH_LO])[*4];
    endsequence

    chk_dir_write: assert property ( // RULE2
        (req.wr && req.addr == bpc_pkg::ADDR_DIRECTION) |=> (pin_oe_n == $past(req.wdata)))
        else $error("direction write not seen on output enables");

    chk_pullup_outputs: assert property ( // RULE4
        (pullup_en & ~pin_oe_n) == 8'h00)
        else $error("pull-up on while pin is driven");

    chk_pullup_global: assert property ( // RULE3
        $rose(option_q[bpc_pkg::PULLUP_DIS_BIT]) |-> (pullup_en == 8'h00))
        else $error("pull-ups stay on after disable");

    chk_change_flag: assert property ( // RULE7
        s_watched_change |=> irq_ctrl_q.change_irq_flag)
        else $error("watched pin change did not set flag");

    chk_access_recapture: assert property ( // RULE8
        port_access |=> (watch_q == $past(watch_pins)) && !mismatch || $changed(watch_pins))
        else $error("port access did not recapture comparison");

    chk_set_wins: assert property ( // RULE17
        (ctrl_wr && !req.wdata[0] && change_set) |=> irq_ctrl_q.change_irq_flag)
        else $error("clear beat hardware set");

    chk_output_ignored: assert property ( // RULE6
        (!mismatch && !irq_ctrl_q.change_irq_flag && !ctrl_wr && watch_inputs == 4'h0)
        |=> !irq_ctrl_q.change_irq_flag)
        else $error("output pin set the change flag");

    chk_irq_gate: assert property ( // RULE16
        change_irq_req |-> irq_ctrl_q.global_irq_enable && $past(change_set || irq_ctrl_q.change_irq_flag))
        else $error("change request without enables and flag");

    chk_pin_sync: assert property ( // RULE15
        s_pin_settle |-> (pins_stable[bpc_pkg::WATCH_LO] == pin_in[bpc_pkg::WATCH_LO]))
        else $error("pin not settled after four cycles");

    chk_wake_halt: assert property ( // RULE10
        (halt && irq_ctrl_q.change_irq_enable && change_set && !ctrl_wr) |=> wake)
        else $error("no wake from halt on change");

    // reset leaves every pin an undriven input with pull-ups off
    chk_reset_regs: assert property ( // RULE5
        $fell(reset) |-> (dir_q == bpc_pkg::RST_DIRECTION) && (option_q == bpc_pkg::RST_OPTIONS))
        else $error("option or direction not at reset value");

    chk_reset_pins: assert property ( // RULE5
        $fell(reset) |-> (pullup_en == bpc_pkg::RST_ZERO) && (pin_oe_n == bpc_pkg::RST_DIRECTION))
        else $error("pins not released after reset");

    // registers only move on their own write
    chk_latch_write: assert property ( // RULE2
        (req.wr && req.addr == bpc_pkg::ADDR_PORT) |=> (pin_out == $past(req.wdata)))
        else $error("port write not seen on output latch");

    chk_latch_hold: assert property ( // RULE2
        !(req.wr && req.addr == bpc_pkg::ADDR_PORT) |=> $stable(pin_out))
        else $error("output latch moved without a write");

    chk_dir_hold: assert property ( // RULE1
        !(req.wr && req.addr == bpc_pkg::ADDR_DIRECTION) |=> $stable(pin_oe_n))
        else $error("direction moved without a write");

    sequence s_option_enable;
        req.wr && req.addr == bpc_pkg::ADDR_OPTIONS && !req.wdata[bpc_pkg::PULLUP_DIS_BIT];
    endsequence

    chk_option_write: assert property ( // RULE3
        s_option_enable |=> (pullup_en == dir_q))
        else $error("pull-ups not on for every input pin");

    chk_pullup_hold: assert property ( // RULE3
        !(req.wr && req.addr == bpc_pkg::ADDR_OPTIONS) |=> $stable(pullup_en) || $changed(pin_oe_n))
        else $error("pull-ups moved without a write");

    // the read path hands over the synchronised pins
    chk_port_read: assert property ( // RULE1
        (req.rd && req.addr == bpc_pkg::ADDR_PORT) |=> (rdata == $past(pins_stable)))
        else $error("port read did not return the pins");

    // a changed synchronised level must be the pad level seen four edges before
    chk_sync_source: assert property ( // RULE15
        ((pins_stable ^ $past(pins_stable)) & (pins_stable ^ $past(pin_in, 4))) == bpc_pkg::RST_ZERO)
        else $error("synchronised pin does not follow its pad");

    // flag sets from a mismatch whatever the enables, falls only on a clear
    chk_set_regardless: assert property ( // RULE12
        (change_set && !irq_ctrl_q.change_irq_enable && !irq_ctrl_q.global_irq_enable)
        |=> irq_ctrl_q.change_irq_flag)
        else $error("flag held back by its enables");

    chk_flag_sticky: assert property ( // RULE9
        (irq_ctrl_q.change_irq_flag && !ctrl_wr) |=> irq_ctrl_q.change_irq_flag)
        else $error("flag fell without a clearing write");

    chk_flag_cause: assert property ( // RULE7
        $rose(irq_ctrl_q.change_irq_flag)
        |-> $past(mismatch || (ctrl_wr && req.wdata[bpc_pkg::EVT_CHANGE_BIT])))
        else $error("flag rose with no mismatch");

    sequence s_quiet_clear;
        ctrl_wr && !req.wdata[bpc_pkg::EVT_CHANGE_BIT] && !change_set;
    endsequence

    chk_flag_clear: assert property ( // RULE9
        s_quiet_clear |=> !irq_ctrl_q.change_irq_flag)
        else $error("flag not cleared once mismatch ended");

    sequence s_read_on_change;
        lost_hit && !irq_ctrl_q.change_irq_flag && !ctrl_wr;
    endsequence

    chk_lost_read: assert property ( // RULE11
        s_read_on_change |=> !irq_ctrl_q.change_irq_flag)
        else $error("change on a read was not dropped");

    chk_req_rise: assert property ( // RULE16
        $rose(change_irq_req) |-> irq_ctrl_q.change_irq_flag && $past(change_set || ctrl_wr))
        else $error("change request rose with no flag or enable update");

    // event status keeps a change even against a clearing write
    chk_status_wins: assert property ( // RULE17
        (req.wr && req.addr == bpc_pkg::ADDR_EVT_STATUS && change_set)
        |=> evt_status_q[bpc_pkg::EVT_CHANGE_BIT])
        else $error("status clear beat a change");

    chk_status_sticky: assert property ( // RULE12
        (evt_status_q[bpc_pkg::EVT_CHANGE_BIT] && !(req.wr && req.addr == bpc_pkg::ADDR_EVT_STATUS))
        |=> evt_status_q[bpc_pkg::EVT_CHANGE_BIT])
        else $error("change status fell without a write");
endmodule

// ---- bpc_pins_model.sv ----
// pin-side model: resolves each pad from port drive, keypad drive and pull-up
module bpc_pins_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] ext_drive,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] noise_q;

    // a pad nobody holds wanders, so a floating read never looks settled
    always_ff @(posedge core_clk) begin
        noise_q <= (noise_q === 8'hxx) ? 8'h55 : ~noise_q;
    end

    // port drive wins, then the keypad, then the weak pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_drive[i]) pin_in[i] = ext_val[i];
            else if (pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = noise_q[i];
        end
    end
endmodule

// ---- bidir_port_change_irq_tb_top.sv ----
// self-checking bench for the bidirectional port with change interrupt
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module bidir_port_change_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk;
    logic       reset;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rdata;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [7:0] pullup_en;
    logic       halt;
    logic       wake;
    logic       change_irq_req;
    logic       irq;
    logic [7:0] ext_drive;
    logic [7:0] ext_val;
    logic [7:0] rd_val;
    logic       lossy_wake;
    int         errors;
    int         n_tests;

    bpc_port i_bpc_port (
        .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .halt(halt), .wake(wake), .change_irq_req(change_irq_req), .irq(irq)
    );
    bpc_pins_model i_bpc_pins_model (
        .core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .ext_drive(ext_drive), .ext_val(ext_val), .pin_in(pin_in)
    );
    // same port, but a port read may swallow a change that lands on it
    bpc_port #(.LOSE_ON_READ(1'b1)) i_bpc_port_lossy (
        .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(), .pin_in(pin_in), .pin_out(), .pin_oe_n(), .pullup_en(),
        .halt(halt), .wake(lossy_wake), .change_irq_req(), .irq()
    );

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    // one-cycle read strobe, data caught in the following cycle only
    task automatic rd(input logic [8:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1 rd_val = rdata;
    endtask

    // poll the control register, which leaves the captured pin value alone
    task automatic wait_flag();
        for (int i = 0; i < 20; i++) begin
            rd(bpc_pkg::ADDR_IRQ_CTRL);
            if (rd_val[0] === 1'b1) return;
        end
        errors++;
        $display("Error at %0t: got %h expected %h", $time, rd_val, 8'h01);
        report_and_stop();
    endtask

    initial begin
        reset = 1'b1;
        addr = 9'h000;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        halt = 1'b0;
        ext_drive = 8'hff;
        ext_val = 8'h00;
        errors = 0;
        n_tests = 0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        // reset values, and an unmapped place reads zero
        rd(bpc_pkg::ADDR_OPTIONS);
        `CHK(rd_val, 8'hff)
        rd(bpc_pkg::ADDR_DIRECTION);
        `CHK(rd_val, 8'hff)
        rd(bpc_pkg::ADDR_IRQ_CTRL_M);
        `CHK(rd_val, 8'h00)
        `CHK({pullup_en, pin_oe_n}, 16'h00ff)
        rd(9'h1c5);
        `CHK(rd_val, 8'h00)
        $display("test reset values done");
        // upper pins as outputs, lower as inputs on pull-ups only
        wr(bpc_pkg::ADDR_DIRECTION, 8'h0f);
        wr(bpc_pkg::ADDR_PORT, 8'ha5);
        wr(bpc_pkg::ADDR_OPTIONS, 8'h7f);
        ext_drive <= 8'h00;
        #1 `CHK({pin_oe_n, pin_out}, 16'h0fa5)
        `CHK(pullup_en, 8'h0f)
        repeat (8) @(posedge core_clk);
        rd(bpc_pkg::ADDR_PORT);
        `CHK(rd_val, 8'haf)
        $display("test direction and pull-ups done");
        // back to inputs, recapture and clear before watching for change
        wr(bpc_pkg::ADDR_DIRECTION, 8'hff);
        wr(bpc_pkg::ADDR_OPTIONS, 8'hff);
        ext_drive <= 8'hff;
        repeat (8) @(posedge core_clk);
        rd(bpc_pkg::ADDR_PORT);
        wr(bpc_pkg::ADDR_IRQ_CTRL, 8'h00);
        wr(bpc_pkg::ADDR_EVT_STATUS, 8'h03);
        ext_val <= 8'h04;
        repeat (12) @(posedge core_clk);
        rd(bpc_pkg::ADDR_IRQ_CTRL);
        `CHK(rd_val, 8'h00)
        ext_val <= 8'h14;
        wait_flag();
        `CHK(rd_val, 8'h01)
        wr(bpc_pkg::ADDR_EVT_MASK, 8'h01);
        #1 `CHK(irq, 1'b1)
        // clearing without a port access does not hold while mismatched
        wr(bpc_pkg::ADDR_IRQ_CTRL, 8'h00);
        rd(bpc_pkg::ADDR_IRQ_CTRL_M);
        `CHK(rd_val, 8'h01)
        rd(bpc_pkg::ADDR_PORT);
        `CHK(rd_val, 8'h14)
        wr(bpc_pkg::ADDR_IRQ_CTRL, 8'h00);
        rd(bpc_pkg::ADDR_IRQ_CTRL);
        `CHK(rd_val, 8'h00)
        wr(bpc_pkg::ADDR_EVT_STATUS, 8'h01);
        rd(bpc_pkg::ADDR_EVT_STATUS);
        `CHK(rd_val, 8'h00)
        #1 `CHK(irq, 1'b0)
        $display("test change detection done");
        // flag is clear before both enables go on; no port reads while armed
        wr(bpc_pkg::ADDR_IRQ_CTRL, 8'h88);
        halt <= 1'b1;
        #1 `CHK({change_irq_req, wake}, 2'b00)
        ext_val <= 8'h34;
        wait_flag();
        #1 `CHK({change_irq_req, wake}, 2'b11)
        rd(bpc_pkg::ADDR_EVT_STATUS);
        `CHK(rd_val, 8'h03)
        wr(bpc_pkg::ADDR_IRQ_CTRL, 8'h08);
        #1 `CHK(change_irq_req, 1'b0)
        $display("test enables and wake done");
        // first mismatch cycle meets a port read: only the lossy port drops it
        rd(bpc_pkg::ADDR_PORT);
        wr(bpc_pkg::ADDR_IRQ_CTRL, 8'h08);
        ext_val <= 8'h74;
        repeat (3) @(posedge core_clk);
        rd(bpc_pkg::ADDR_PORT);
        `CHK(rd_val, 8'h74)
        #1 `CHK({wake, lossy_wake}, 2'b10)
        $display("test read on change done");
        report_and_stop();
    end
endmodule
